/* verilog/tcs_pkg.sv */
// constants of the timer control/status and counter block
// assumes a 32-bit apb slave, one word per 8-bit register
//
// Overview of operation
// (R1) overflow flag, bit 7, sets when counter wraps to 0x0000 past modulo.
// (R2) flag clears only after a status read with flag set, then zero write.
// (R3) overflow between that read and write restarts the clear sequence.
// (R4) writing one to the overflow flag leaves it unchanged.
// (R5) interrupt request is flag and enable bit 6; enable zero suppresses it.
// (R6) bit 5 zero counts up only; one counts up/down, all channels centered.
// (R7) without center mode each channel follows its own mode bits.
// (R8) bits 4:3 pick source: none, bus clock, fixed clock, external.
// (R9) without an enabled pll or fll the fixed clock acts as bus clock.
// (R10) external source synchronised here; fixed clock arrives synchronised.
// (R11) prescale field divides the source by two to its value, 1 to 128.
// (R12) divider sits after selection and sync; only its output steps counter.
// (R13) a new prescale value acts the cycle after it is stored.
// (R14) reading either counter byte latches both until the other is read.
// (R15) reset or any status write restarts counter read latching.
// (R16) any counter byte write clears the counter and restarts latching.
// (R17) reset leaves the counter at zero.
// (R18) in debug halt the counter stops and reads show frozen value.
// (R19) in debug halt counter reads leave the latch state untouched.
// (R20) in debug halt status or counter writes still restart latching.
// (R21) after equalling modulo counter restarts at zero; modulo zero free-runs.
// (R22) counter moves one per prescaled tick, holds while source is none.
package tcs_pkg;
    localparam logic [7:0]  OFS_CONTROL_STATUS = 8'h00;
    localparam logic [7:0]  OFS_COUNTER_HIGH   = 8'h04;
    localparam logic [7:0]  OFS_COUNTER_LOW    = 8'h08;
    localparam int unsigned BIT_OVERFLOW       = 7;
    localparam int unsigned BIT_IRQ_ENABLE     = 6;
    localparam int unsigned BIT_CENTER         = 5;
    localparam int unsigned CLKS_LSB           = 3;
    localparam int unsigned PRESCALE_LSB       = 0;
    localparam logic [6:0]  CONTROL_RESET      = 7'h00;
    localparam logic [15:0] COUNTER_RESET      = 16'h0000;
    localparam logic [15:0] COUNTER_FULL       = 16'hffff;
    localparam logic [6:0]  PRESCALE_RESET     = 7'h00;
    localparam logic [1:0]  CENTER_MODE_CODE   = 2'b11;
    typedef enum logic [1:0] {
        SRC_NONE  = 2'b00,
        SRC_BUS   = 2'b01,
        SRC_FIXED = 2'b10,
        SRC_EXT   = 2'b11
    } tcs_source_type;
endpackage

/* verilog/tcs_timer_ctrl.sv */
// timer control/status register, clock select, prescaler, 16-bit counter
// assumes apb master on clock_i; halt, pll flag, fixed tick from clock_i
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tcs_timer_ctrl #(
    parameter int CHANNELS = 2
) (
    input  wire logic                  clock_i,
    input  wire logic                  rstn_i,
    input  wire logic                  clock_enable_i,
    input  wire logic                  psel_i,
    input  wire logic                  penable_i,
    input  wire logic                  pwrite_i,
    input  wire logic [7:0]            paddr_i,
    input  wire logic [31:0]           pwdata_i,
    output logic      [31:0]           prdata_o,
    output logic                       pready_o,
    output logic                       pslverr_o,
    input  wire logic                  ext_clock_i,
    input  wire logic                  fixed_tick_i,
    input  wire logic                  pll_enabled_i,
    input  wire logic                  debug_halt_mode_i,
    input  wire logic [15:0]           modulo_value_i,
    input  wire logic [2*CHANNELS-1:0] channel_mode_select_i,
    output logic      [2*CHANNELS-1:0] channel_mode_o,
    output logic                       center_align_o,
    output logic                       count_down_o,
    output logic      [15:0]           counter_o,
    output logic                       overflow_irq_o
);

    if (CHANNELS < 1 || CHANNELS > 8) begin : g_check
        $error("CHANNELS must be 1 to 8");
    end

    function automatic logic word_is(input logic [7:0] a,
                                     input logic [7:0] ofs);
        word_is = (a[7:2] == ofs[7:2]);
    endfunction

    function automatic logic [6:0] ps_mask(input logic [2:0] ps);
        ps_mask = 7'((8'h01 << ps) - 8'h01);
    endfunction

    // reset release
    logic rst_q1;
    logic rst_n;
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // external source sync; first stage feeds only the second
    logic ext_q1;
    logic ext_q2;
    logic ext_q3;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            ext_q1 <= 1'b0;
            ext_q2 <= 1'b0;
            ext_q3 <= 1'b0;
        end else if (clock_enable_i) begin
            ext_q1 <= ext_clock_i; // R10
            ext_q2 <= ext_q1;
            ext_q3 <= ext_q2;
        end
    end

    // bus decode
    logic setup;
    logic rd_setup;
    logic wr_done;
    logic hit_sc;
    logic hit_h;
    logic hit_l;
    logic hit_cnt;
    assign setup    = psel_i & ~penable_i;
    assign rd_setup = setup & ~pwrite_i;
    assign wr_done  = psel_i & penable_i & pready_o & pwrite_i;
    assign hit_sc   = word_is(paddr_i, tcs_pkg::OFS_CONTROL_STATUS);
    assign hit_h    = word_is(paddr_i, tcs_pkg::OFS_COUNTER_HIGH);
    assign hit_l    = word_is(paddr_i, tcs_pkg::OFS_COUNTER_LOW);
    assign hit_cnt  = hit_h | hit_l;

    // control, flag and clear sequence
    logic [6:0] control;
    logic [6:0] next_control;
    logic       flag;
    logic       next_flag;
    logic       armed;
    logic       next_armed;
    logic       ovf;
    logic       next_irq;
    logic       center;
    logic [1:0] clks;
    logic [2:0] ps;
    assign center = control[tcs_pkg::BIT_CENTER];
    assign clks   = control[tcs_pkg::CLKS_LSB +: 2];
    assign ps     = control[tcs_pkg::PRESCALE_LSB +: 3];

    always_comb begin
        next_control = control;
        next_flag    = flag;
        next_armed   = armed;
        if (rd_setup && hit_sc && flag) begin
            next_armed = 1'b1; // R2
        end
        if (wr_done && hit_sc) begin
            next_control = pwdata_i[6:0];
            // a one in bit 7 is simply ignored
            if (!pwdata_i[tcs_pkg::BIT_OVERFLOW] && armed) begin // R4
                next_flag = 1'b0; // R2
            end
            next_armed = 1'b0;
        end
        // set beats clear so no overflow is lost
        if (ovf) begin
            next_flag  = 1'b1; // R1
            next_armed = 1'b0; // R3
        end
        next_irq = next_flag & next_control[tcs_pkg::BIT_IRQ_ENABLE]; // R5
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            control        <= tcs_pkg::CONTROL_RESET;
            flag           <= 1'b0;
            armed          <= 1'b0;
            overflow_irq_o <= 1'b0;
        end else if (clock_enable_i) begin
            control        <= next_control;
            flag           <= next_flag;
            armed          <= next_armed;
            overflow_irq_o <= next_irq;
        end
    end

    // source select, prescaler and counter
    logic [6:0]  presc;
    logic [6:0]  next_presc;
    logic [15:0] next_counter;
    logic        next_down;
    logic        src;
    logic        go;
    logic        tick;
    logic        cnt_wr;
    logic [15:0] mod_top;
    assign cnt_wr  = wr_done & hit_cnt;
    assign mod_top = (modulo_value_i == tcs_pkg::COUNTER_RESET)
                   ? tcs_pkg::COUNTER_FULL : modulo_value_i; // R21

    always_comb begin
        case (tcs_pkg::tcs_source_type'(clks)) // R8
            tcs_pkg::SRC_NONE:  src = 1'b0; // R22
            tcs_pkg::SRC_BUS:   src = 1'b1;
            tcs_pkg::SRC_FIXED: src = pll_enabled_i ? fixed_tick_i : 1'b1; // R9
            tcs_pkg::SRC_EXT:   src = ext_q2 & ~ext_q3; // R10
            default:            src = 1'b0;
        endcase
        go = src & ~debug_halt_mode_i; // R18
    end

    always_comb begin
        next_presc   = presc;
        next_counter = counter_o;
        // leaving center mode must not keep a stale down state
        next_down    = count_down_o & center; // R6
        tick         = 1'b0;
        ovf          = 1'b0;
        // mask read straight from the stored field: acts next cycle
        if (go) begin
            if ((presc & ps_mask(ps)) == ps_mask(ps)) begin // R11 R13
                tick       = 1'b1;
                next_presc = tcs_pkg::PRESCALE_RESET;
            end else begin
                next_presc = presc + 7'h01;
            end
        end
        if (tick) begin // R12
            if (!center) begin // R6
                next_down = 1'b0;
                if (counter_o >= mod_top) begin
                    next_counter = tcs_pkg::COUNTER_RESET; // R21
                    ovf          = 1'b1; // R1
                end else begin
                    next_counter = counter_o + 16'h0001; // R22
                end
            end else if (!count_down_o) begin
                if (counter_o >= mod_top) begin
                    next_down    = 1'b1;
                    next_counter = counter_o - 16'h0001;
                    ovf          = 1'b1;
                end else begin
                    next_counter = counter_o + 16'h0001;
                end
            end else if (counter_o == tcs_pkg::COUNTER_RESET) begin
                next_down    = 1'b0;
                next_counter = counter_o + 16'h0001;
            end else begin
                next_counter = counter_o - 16'h0001;
            end
        end
        // data is ignored on counter writes
        if (cnt_wr) begin
            next_counter = tcs_pkg::COUNTER_RESET; // R16
            next_presc   = tcs_pkg::PRESCALE_RESET;
            next_down    = 1'b0;
            ovf          = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            presc        <= tcs_pkg::PRESCALE_RESET;
            counter_o    <= tcs_pkg::COUNTER_RESET; // R17
            count_down_o <= 1'b0;
        end else if (clock_enable_i) begin
            presc        <= next_presc;
            counter_o    <= next_counter;
            count_down_o <= next_down;
        end
    end

    // coherent counter reads
    logic        buf_valid;
    logic        next_buf_valid;
    logic        buf_hi_first;
    logic        next_buf_hi_first;
    logic [15:0] buf_value;
    logic [15:0] next_buf_value;
    logic [15:0] rd_view;
    assign rd_view = buf_valid ? buf_value : counter_o; // R14

    always_comb begin
        next_buf_valid    = buf_valid;
        next_buf_hi_first = buf_hi_first;
        next_buf_value    = buf_value;
        // halt leaves a half-done read intact
        if (!debug_halt_mode_i && rd_setup && hit_cnt) begin // R19
            if (!buf_valid) begin
                next_buf_valid    = 1'b1; // R14
                next_buf_hi_first = hit_h;
                next_buf_value    = counter_o;
            end else if (hit_h != buf_hi_first) begin
                next_buf_valid = 1'b0;
            end
        end
        if (wr_done && (hit_sc || hit_cnt)) begin
            next_buf_valid = 1'b0; // R15 R16 R20
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            buf_valid    <= 1'b0; // R15
            buf_hi_first <= 1'b0;
            buf_value    <= tcs_pkg::COUNTER_RESET;
        end else if (clock_enable_i) begin
            buf_valid    <= next_buf_valid;
            buf_hi_first <= next_buf_hi_first;
            buf_value    <= next_buf_value;
        end
    end

    // apb answer: read data chosen at setup, ready in the access cycle
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    always_comb begin
        next_prdata  = prdata_o;
        next_pready  = setup;
        next_pslverr = setup & ~(hit_sc | hit_cnt);
        if (setup) begin
            next_prdata = 32'h0000_0000;
            if (!pwrite_i && hit_sc) begin
                next_prdata[7:0] = {flag, control};
            end else if (!pwrite_i && hit_h) begin
                next_prdata[7:0] = rd_view[15:8]; // R18
            end else if (!pwrite_i && hit_l) begin
                next_prdata[7:0] = rd_view[7:0];
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else if (clock_enable_i) begin
            prdata_o  <= next_prdata;
            pready_o  <= next_pready;
            pslverr_o <= next_pslverr;
        end
    end

    // channel modes seen by the channel logic
    logic [2*CHANNELS-1:0] next_chmode;
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        assign next_chmode[2*g +: 2] = center
            ? tcs_pkg::CENTER_MODE_CODE // R6
            : channel_mode_select_i[2*g +: 2]; // R7
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            channel_mode_o <= '0;
            center_align_o <= 1'b0;
        end else if (clock_enable_i) begin
            channel_mode_o <= next_chmode;
            center_align_o <= center;
        end
    end

    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n);

    a_flag_on_wrap: // R1
    assert property (clock_enable_i && tick && !center && !cnt_wr
                     && counter_o == mod_top |=> flag)
        else $error("overflow flag not set on wrap");

    a_mod_restart: // R21
    assert property (clock_enable_i && tick && !center && !cnt_wr
                     && counter_o == mod_top |=> counter_o == 16'h0000)
        else $error("counter did not restart at zero");

    a_clear_needs_read: // R2
    assert property (clock_enable_i && flag && !armed |=> flag)
        else $error("flag cleared without status read");

    a_clear_done: // R2
    assert property (clock_enable_i && wr_done && hit_sc && armed
                     && !pwdata_i[7] && !ovf |=> !flag)
        else $error("clear sequence did not clear flag");

    a_new_ovf_rearm: // R3
    assert property (clock_enable_i && ovf |=> flag && !armed)
        else $error("overflow did not restart clear sequence");

    a_one_write_keeps: // R4
    assert property (clock_enable_i && wr_done && hit_sc && flag
                     && pwdata_i[7] |=> flag)
        else $error("writing one changed the flag");

    a_irq_gating: // R5
    assert property (##1 overflow_irq_o == (flag && control[6]))
        else $error("interrupt request does not track flag");

    a_up_only: // R6
    assert property (clock_enable_i && !center |=> !count_down_o)
        else $error("down count outside center mode");

    a_hold_no_src: // R22
    assert property (clock_enable_i && clks == 2'b00 && !cnt_wr
                     |=> $stable(counter_o))
        else $error("counter moved with no source");

    a_halt_freeze: // R18
    assert property (debug_halt_mode_i && !cnt_wr
                     ##1 debug_halt_mode_i && !cnt_wr
                     |-> $stable(counter_o) [*2])
        else $error("counter moved in halt");

    a_halt_buffer: // R19
    assert property (clock_enable_i && debug_halt_mode_i
                     && !(wr_done && (hit_sc || hit_cnt))
                     |=> $stable(buf_valid))
        else $error("halt read changed latch state");

    a_cnt_write_clr: // R16
    assert property (clock_enable_i && cnt_wr
                     |=> counter_o == 16'h0000 && !buf_valid)
        else $error("counter write did not clear");

    a_sc_write_restart: // R20
    assert property (clock_enable_i && wr_done && hit_sc |=> !buf_valid)
        else $error("status write did not restart latching");

    c_clear_sequence:
    cover property (flag && armed ##[1:20] !flag);
    c_coherent_pair:
    cover property (buf_valid && rd_setup && hit_cnt
                    && hit_h != buf_hi_first);
    c_center_turn:
    cover property (center && ovf);
    c_halt_half_read:
    cover property (debug_halt_mode_i && buf_valid);

endmodule

/* tb/tcs_timer_ctrl_test.sv */
// self-checking bench for the timer control/status and counter block
// assumes apb with one wait-free access cycle; bench drives every input
`timescale 1ns/1ps
module tcs_timer_ctrl_test;
    logic        clock_i    = 1'b0;
    logic        rstn_i     = 1'b0;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [7:0]  paddr_i    = 8'h00;
    logic [31:0] pwdata_i   = 32'h0;
    logic        ext_i      = 1'b0;
    logic        tick_i     = 1'b0;
    logic        pll_i      = 1'b1;
    logic        halt_i     = 1'b0;
    logic [15:0] modulo_i   = 16'h0000;
    logic [1:0]  tick_cnt   = 2'b00;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    logic [3:0]  chan_mode_o;
    logic        center_o;
    logic        down_o;
    logic [15:0] counter_o;
    logic        irq_o;
    logic [31:0] rdata;
    logic        rerr;
    int          errors = 0;
    int          total_checks = 0;
    int          changes;

    tcs_timer_ctrl uut (
        .clock_i               (clock_i),
        .rstn_i                (rstn_i),
        .clock_enable_i        (1'b1),
        .psel_i                (psel_i),
        .penable_i             (penable_i),
        .pwrite_i              (pwrite_i),
        .paddr_i               (paddr_i),
        .pwdata_i              (pwdata_i),
        .prdata_o              (prdata_o),
        .pready_o              (pready_o),
        .pslverr_o             (pslverr_o),
        .ext_clock_i           (ext_i),
        .fixed_tick_i          (tick_i),
        .pll_enabled_i         (pll_i),
        .debug_halt_mode_i     (halt_i),
        .modulo_value_i        (modulo_i),
        .channel_mode_select_i (4'b1001),
        .channel_mode_o        (chan_mode_o),
        .center_align_o        (center_o),
        .count_down_o          (down_o),
        .counter_o             (counter_o),
        .overflow_irq_o        (irq_o)
    );

    always #2.5 clock_i = ~clock_i;

    // fixed clock stand-in: one pulse every fourth cycle
    always @(posedge clock_i) begin
        tick_cnt <= tick_cnt + 2'b01;
        tick_i   <= (tick_cnt == 2'b00);
    end

    task end_sim();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; ends with one idle cycle so signals change once
    task apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int n;
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= addr;
        pwdata_i  <= {24'h0, data};
        @(posedge clock_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (pready_o !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t no bus answer", $time);
            end_sim();
        end
        rdata = prdata_o;
        rerr  = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask

    task wr(input logic [7:0] addr, input logic [7:0] data);
        apb(1'b1, addr, data);
    endtask

    task rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        apb(1'b0, addr, 8'h00);
        chk(rdata[15:0], {8'h00, exp}, what);
    endtask

    task ext_pulses(input int n);
        repeat (n) begin
            ext_i <= 1'b1;
            repeat (4) @(posedge clock_i);
            ext_i <= 1'b0;
            repeat (4) @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask

    task count_changes(input int n);
        logic [15:0] prev;
        prev    = counter_o;
        changes = 0;
        repeat (n) begin
            @(posedge clock_i);
            if (counter_o !== prev) changes++;
            prev = counter_o;
        end
    endtask

    task settle();
        repeat (2) @(posedge clock_i);
    endtask

    initial begin
        repeat (100000) @(posedge clock_i);
        errors++;
        $display("[FAIL] %0t run limit reached", $time);
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clock_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        // reset state and unmapped access
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'h00, "status reset");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "count hi reset");
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h00, "count lo reset");
        apb(1'b0, 8'h0c, 8'h00);
        chk({15'h0, rerr}, 16'h0001, "unmapped error");
        $display("test reset done");
        // overflow flag, clear sequence, interrupt
        modulo_i <= 16'h0003;
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h08);
        repeat (10) @(posedge clock_i);
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h00);
        settle();
        chk({15'h0, irq_o}, 16'h0000, "irq masked");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'hc0);
        settle();
        chk({15'h0, irq_o}, 16'h0001, "irq raised");
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'hc0, "flag read");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h40);
        settle();
        chk({15'h0, irq_o}, 16'h0000, "irq cleared");
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'h40, "flag cleared");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h48);
        repeat (10) @(posedge clock_i);
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'hc8, "flag again");
        repeat (10) @(posedge clock_i);
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h48);
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h40);
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'hc0, "flag kept");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h00);
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'h00, "flag gone");
        $display("test flag done");
        // prescaler: every code, 8 ticks over 8 divided periods
        modulo_i <= 16'h0000;
        for (int k = 0; k < 8; k++) begin
            wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h08 | k[7:0]);
            repeat ((1 << k) + 4) @(posedge clock_i);
            count_changes(8 << k);
            chk(changes[15:0], 16'd8, "prescale ticks");
        end
        // sources: fixed, fixed without pll, none
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h10);
        repeat (8) @(posedge clock_i);
        count_changes(32);
        chk(changes[15:0], 16'd8, "fixed ticks");
        pll_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        count_changes(32);
        chk(changes[15:0], 16'd32, "fixed as bus");
        pll_i <= 1'b1;
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h00);
        count_changes(32);
        chk(changes[15:0], 16'd0, "no source");
        $display("test sources done");
        // coherent reads with the external source
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h18);
        wr(tcs_pkg::OFS_COUNTER_HIGH, 8'h5a);
        ext_pulses(5);
        chk(counter_o, 16'h0005, "ext count");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi first");
        ext_pulses(3);
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h05, "lo latched");
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h08, "lo fresh");
        ext_pulses(2);
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h08, "lo reread");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h18);
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h0a, "after status");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi release");
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h0a, "lo latch");
        ext_pulses(1);
        wr(tcs_pkg::OFS_COUNTER_LOW, 8'hff);
        settle();
        chk(counter_o, 16'h0000, "count cleared");
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h00, "after clear");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi release");
        $display("test coherency done");
        // debug halt
        ext_pulses(6);
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi before halt");
        ext_pulses(1);
        halt_i <= 1'b1;
        ext_pulses(2);
        chk(counter_o, 16'h0007, "frozen");
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h06, "lo in halt");
        halt_i <= 1'b0;
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h06, "lo after halt");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi latch");
        halt_i <= 1'b1;
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h18);
        halt_i <= 1'b0;
        ext_pulses(1);
        rd_chk(tcs_pkg::OFS_COUNTER_LOW, 8'h08, "halt restart");
        rd_chk(tcs_pkg::OFS_COUNTER_HIGH, 8'h00, "hi release");
        $display("test halt done");
        // center mode and up-mode wrap at modulo
        modulo_i <= 16'h0003;
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h38);
        wr(tcs_pkg::OFS_COUNTER_HIGH, 8'h00);
        settle();
        chk({11'h0, center_o, chan_mode_o}, 16'h001f, "center on");
        ext_pulses(4);
        chk(counter_o, 16'h0002, "center down");
        chk({15'h0, down_o}, 16'h0001, "down flag");
        ext_pulses(2);
        chk(counter_o, 16'h0000, "center bottom");
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'hb8, "center flag");
        wr(tcs_pkg::OFS_CONTROL_STATUS, 8'h18);
        settle();
        chk({11'h0, center_o, chan_mode_o}, 16'h0009, "center off");
        chk({15'h0, down_o}, 16'h0000, "up only");
        wr(tcs_pkg::OFS_COUNTER_LOW, 8'h00);
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'h18, "flag clear");
        ext_pulses(3);
        chk(counter_o, 16'h0003, "at modulo");
        ext_pulses(1);
        chk(counter_o, 16'h0000, "wrapped");
        rd_chk(tcs_pkg::OFS_CONTROL_STATUS, 8'h98, "wrap flag");
        $display("test modes done");
        end_sim();
    end
endmodule
